// *** inc/vliw_fd_defines.svh ***
// constants for the vliw fetch and dispatch front end
`ifndef VLIW_FD_DEFINES_SVH
`define VLIW_FD_DEFINES_SVH

// packet geometry
`define FETCH_BITS 256
`define WORD_BITS 32
`define SLOTS 8
`define UNITS 8
`define UNITS_PER_SIDE 4
`define REG_COUNT 16
`define FETCH_STEP 32'h00000020
`define RESET_PC 32'h00000000

// common instruction fields
`define CHAIN_BIT 0
`define UNIT_LSB 1
`define UNIT_MSB 3
`define CREG_MSB 31
`define CREG_LSB 29
`define ZERO_BIT 28

// compute unit fields
`define DST_MSB 27
`define DST_LSB 24
`define DST_X_BIT 23
`define SRC1_MSB 22
`define SRC1_LSB 19
`define SRC1_X_BIT 18
`define SRC2_MSB 17
`define SRC2_LSB 14
`define FP_BIT 13

// address unit fields, short form
`define LONG_BIT 22
`define BASE_MSB 21
`define BASE_LSB 18
`define CIRC_BIT 17
`define DW_BIT 16
`define STORE_BIT 15
`define SIZE_MSB 14
`define SIZE_LSB 13
`define SOFF_MSB 12
`define SOFF_LSB 8
// address unit fields, long form
`define LOFF_MSB 21
`define LOFF_LSB 7
`define LSTORE_BIT 6
`define LSIZE_MSB 5
`define LSIZE_LSB 4
`define LONG_BASE 4'hE
`define OFF_BITS 15

// condition register codes
`define CREG_ALWAYS 3'h0
`define CREG_B0 3'h1
`define CREG_B1 3'h2
`define CREG_B2 3'h3
`define CREG_A1 3'h4
`define CREG_A2 3'h5

`endif

// *** inc/vliw_fd_pkg.sv ***
// types for the vliw fetch and dispatch front end
package vliw_fd_pkg;

  typedef enum logic [2:0] {
    LOGIC_UNIT_A    = 3'h0,
    SHIFT_UNIT_A    = 3'h1,
    MULTIPLY_UNIT_A = 3'h2,
    ADDRESS_UNIT_A  = 3'h3,
    LOGIC_UNIT_B    = 3'h4,
    SHIFT_UNIT_B    = 3'h5,
    MULTIPLY_UNIT_B = 3'h6,
    ADDRESS_UNIT_B  = 3'h7
  } unit_id_type;

  typedef enum logic [1:0] {
    ST_IDLE     = 2'h0,
    ST_REQ      = 2'h1,
    ST_DISPATCH = 2'h2
  } fetch_state_type;

  typedef enum logic [1:0] {
    SIZE_BYTE = 2'h0,
    SIZE_HALF = 2'h1,
    SIZE_WORD = 2'h2
  } mem_size_type;

endpackage

// *** rtl/packet_splitter.sv ***
// finds the issue group that starts at a given slot of a fetch packet
`timescale 1ns/1ps
`include "vliw_fd_defines.svh"
module packet_splitter (
  // packet view
  input wire logic [7:0] chain_i,
  input wire logic [2:0] start_i,
  // group found
  output logic [7:0] mask_o,
  output logic [2:0] last_o,
  output logic done_o
);

  // a slot closes its group when its chain bit is clear; the last slot always closes
  wire [7:0] stop = {1'b1, ~chain_i[6:0]};
  wire [7:0] from = 8'hFF << start_i;
  wire [7:0] cand = stop & from;
  wire [7:0] end_hot = cand & (~cand + 8'h01);
  // every slot from start through the closing slot joins the group
  wire [8:0] below = {end_hot, 1'b0} - 9'h001;

  function automatic logic [2:0] encode8(input logic [7:0] hot);
    logic [2:0] idx;
    idx = 3'h0;
    for (int s = 0; s < `SLOTS; s++) begin
      if (hot[s]) idx = s[2:0];
    end
    return idx;
  endfunction

  assign mask_o = from & below[7:0];
  assign last_o = encode8(end_hot);
  assign done_o = end_hot[`SLOTS-1];

endmodule // packet_splitter

// *** rtl/unit_router.sv ***
// steers each word of an issue group to the functional unit it names
`timescale 1ns/1ps
`include "vliw_fd_defines.svh"
module unit_router (
  // group in
  input wire logic [`FETCH_BITS-1:0] packet_i,
  input wire logic [7:0] mask_i,
  input wire logic enable_i,
  // per-unit out
  output logic [`UNITS-1:0] valid_o,
  output logic [`FETCH_BITS-1:0] instr_o,
  output logic clash_o
);

  // slots of the group whose unit field names unit u
  function automatic logic [7:0] slot_hits(input logic [`FETCH_BITS-1:0] pkt, input logic [7:0] m,
                                           input logic [2:0] u);
    logic [7:0] h;
    h = 8'h00;
    for (int s = 0; s < `SLOTS; s++) begin
      h[s] = m[s] & (pkt[s*`WORD_BITS+`UNIT_LSB +: 3] == u);
    end
    return h;
  endfunction

  // or of the hit slots; a duplicate unit merges words, which is undefined anyway
  function automatic logic [`WORD_BITS-1:0] pick(input logic [`FETCH_BITS-1:0] pkt, input logic [7:0] h);
    logic [`WORD_BITS-1:0] w;
    w = '0;
    for (int s = 0; s < `SLOTS; s++) begin
      if (h[s]) w = w | pkt[s*`WORD_BITS +: `WORD_BITS];
    end
    return w;
  endfunction

  logic [`UNITS-1:0] dup;

  for (genvar u = 0; u < `UNITS; u++) begin : g_route
    wire [7:0] hit = slot_hits(packet_i, mask_i, 3'(u));
    // a unit with no word in the group stays idle
    assign valid_o[u] = enable_i & (|hit);
    assign instr_o[u*`WORD_BITS +: `WORD_BITS] = pick(packet_i, hit);
    assign dup[u] = enable_i & ((hit & (hit - 8'h01)) != 8'h00);
  end

  assign clash_o = |dup;

endmodule // unit_router

// *** rtl/vliw_fetch_dispatch_unit.sv ***
// fetch, split, route and register-file front end of the two-sided vliw core
`timescale 1ns/1ps
`include "vliw_fd_defines.svh"
module vliw_fetch_dispatch_unit import vliw_fd_pkg::*; (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // program memory
  output logic fetch_req_o,
  output logic [31:0] fetch_addr_o,
  input wire logic fetch_valid_i,
  input wire logic [`FETCH_BITS-1:0] fetch_data_i,
  // dispatch to the eight units
  output logic group_valid_o,
  output logic [`UNITS-1:0] unit_valid_o,
  output logic [`FETCH_BITS-1:0] unit_instr_o,
  output logic [`UNITS-1:0] unit_fp_o,
  output logic [`FETCH_BITS-1:0] src1_data_o,
  output logic [`FETCH_BITS-1:0] src2_data_o,
  // address unit decode, index 0 is side a
  output logic [2*`OFF_BITS-1:0] agu_offset_o,
  output logic [1:0] agu_circular_o,
  output logic [3:0] agu_size_o,
  output logic [1:0] agu_dw_o,
  output logic [1:0] agu_store_o,
  // results written back by the units
  input wire logic [`UNITS-1:0] wb_en_i,
  input wire logic [`UNITS*4-1:0] wb_addr_i,
  input wire logic [`UNITS-1:0] wb_cross_i,
  input wire logic [`FETCH_BITS-1:0] wb_data_i,
  input wire logic [1:0] dw_en_i,
  input wire logic [2*`WORD_BITS-1:0] dw_data_i,
  // fault flags
  output logic cross_read_conflict_o,
  output logic cross_write_conflict_o,
  output logic unit_clash_o
);


  // shared decode helpers


  // maps a condition code to {known, side, register index}
  function automatic logic [5:0] creg_map(input logic [2:0] c);
    logic [5:0] r;
    case (c)
      `CREG_B0: r = {1'b1, 1'b1, 4'h0};
      `CREG_B1: r = {1'b1, 1'b1, 4'h1};
      `CREG_B2: r = {1'b1, 1'b1, 4'h2};
      `CREG_A1: r = {1'b1, 1'b0, 4'h1};
      `CREG_A2: r = {1'b1, 1'b0, 4'h2};
      default: r = 6'h00;
    endcase
    return r;
  endfunction

  // lowest requester of one side wins its single cross bus
  function automatic logic [3:0] first4(input logic [3:0] r);
    return r & (~r + 4'h1);
  endfunction


  // fetch sequencing

  fetch_state_type state_q;
  fetch_state_type state_d;
  logic [31:0] pc_q;
  logic [31:0] pc_d;
  logic [2:0] start_q;
  logic [2:0] start_d;
  logic [`FETCH_BITS-1:0] packet_q;
  logic fetch_req_q;
  logic [31:0] fetch_addr_q;

  wire [7:0] group_mask;
  wire [2:0] group_last;
  wire packet_done;
  wire dispatching = (state_q == ST_DISPATCH);
  wire packet_taken = (state_q == ST_REQ) & fetch_valid_i;

  // chain bits of all eight slots
  wire [7:0] chain_bits;
  for (genvar s = 0; s < `SLOTS; s++) begin : g_chain
    assign chain_bits[s] = packet_q[s*`WORD_BITS + `CHAIN_BIT];
  end

  // one group leaves per cycle; the packet is refetched only after its last group
  always_comb begin
    state_d = state_q;
    pc_d = pc_q;
    start_d = start_q;
    case (state_q)
      ST_IDLE: begin
        state_d = ST_REQ;
      end
      ST_REQ: begin
        if (fetch_valid_i) begin
          state_d = ST_DISPATCH;
          start_d = 3'h0;
        end
      end
      ST_DISPATCH: begin
        start_d = group_last + 3'h1;
        if (packet_done) begin
          state_d = ST_REQ;
          pc_d = pc_q + `FETCH_STEP;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // sequencer registers; the request is a flop so the pin never glitches
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= ST_IDLE;
      pc_q <= `RESET_PC;
      start_q <= 3'h0;
      fetch_req_q <= 1'b0;
      fetch_addr_q <= `RESET_PC;
    end else begin
      state_q <= state_d;
      pc_q <= pc_d;
      start_q <= start_d;
      fetch_req_q <= (state_d == ST_REQ);
      fetch_addr_q <= pc_d;
    end
  end

  // whole packet captured at once, however many groups it holds
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      packet_q <= '0;
    end else if (packet_taken) begin
      packet_q <= fetch_data_i;
    end
  end


  // split and route

  wire [`UNITS-1:0] route_valid;
  wire [`FETCH_BITS-1:0] route_instr;
  wire route_clash;

  packet_splitter u_splitter (
    .chain_i (chain_bits),
    .start_i (start_q),
    .mask_o  (group_mask),
    .last_o  (group_last),
    .done_o  (packet_done)
  );

  unit_router u_router (
    .packet_i (packet_q),
    .mask_i   (group_mask),
    .enable_i (dispatching),
    .valid_o  (route_valid),
    .instr_o  (route_instr),
    .clash_o  (route_clash)
  );


  // register files: two sides of sixteen words

  logic [`WORD_BITS-1:0] rf_q [0:1][0:`REG_COUNT-1];

  // per-unit decode results
  wire [`UNITS-1:0] issue;
  wire [`UNITS-1:0] xr_req;
  wire [`UNITS-1:0] xr_grant;
  wire [`UNITS-1:0] rd1_x;
  wire [`UNITS-1:0] rd2_x;
  wire [`UNITS-1:0] fp_ok;
  wire [`FETCH_BITS-1:0] rd1_data;
  wire [`FETCH_BITS-1:0] rd2_data;
  wire [2*`OFF_BITS-1:0] agu_off;
  wire [1:0] agu_circ;
  wire [3:0] agu_size;
  wire [1:0] agu_dw;
  wire [1:0] agu_st;

  // each side owns one cross read bus
  assign xr_grant = {first4(xr_req[7:4]), first4(xr_req[3:0])};

  for (genvar u = 0; u < `UNITS; u++) begin : g_unit
    localparam logic SIDE = (u >= `UNITS_PER_SIDE);
    localparam logic IS_ADDR = ((u % `UNITS_PER_SIDE) == 3);
    wire [`WORD_BITS-1:0] ins = route_instr[u*`WORD_BITS +: `WORD_BITS];
    // condition test against the designated register
    wire [5:0] cm = creg_map(ins[`CREG_MSB:`CREG_LSB]);
    wire [`WORD_BITS-1:0] cval = rf_q[cm[4]][cm[3:0]];
    wire c_always = (ins[`CREG_MSB:`CREG_LSB] == `CREG_ALWAYS);
    wire c_hit = ins[`ZERO_BIT] ? (cval == '0) : (cval != '0);
    assign issue[u] = route_valid[u] & (c_always | (cm[5] & c_hit));
    // address unit fields, short and long offset forms
    wire lng = ins[`LONG_BIT];
    wire st = lng ? ins[`LSTORE_BIT] : ins[`STORE_BIT];
    wire [3:0] base_idx = lng ? `LONG_BASE : ins[`BASE_MSB:`BASE_LSB];
    // address units read base on own side and store data on either side
    wire s1 = IS_ADDR ? SIDE : (SIDE ^ ins[`SRC1_X_BIT]);
    wire [3:0] i1 = IS_ADDR ? base_idx : ins[`SRC1_MSB:`SRC1_LSB];
    wire s2 = IS_ADDR ? (SIDE ^ ins[`DST_X_BIT]) : SIDE;
    wire [3:0] i2 = IS_ADDR ? ins[`DST_MSB:`DST_LSB] : ins[`SRC2_MSB:`SRC2_LSB];
    assign rd1_x[u] = ~IS_ADDR & ins[`SRC1_X_BIT];
    assign rd2_x[u] = IS_ADDR & st & ins[`DST_X_BIT];
    assign xr_req[u] = issue[u] & (rd1_x[u] | rd2_x[u]);
    // same-side reads are unrestricted; a losing cross read sees zero
    assign rd1_data[u*`WORD_BITS +: `WORD_BITS] = (rd1_x[u] & ~xr_grant[u]) ? '0 : rf_q[s1][i1];
    assign rd2_data[u*`WORD_BITS +: `WORD_BITS] = (rd2_x[u] & ~xr_grant[u]) ? '0 : rf_q[s2][i2];
    // floating point only outside the address units
    assign fp_ok[u] = issue[u] & ~IS_ADDR & ins[`FP_BIT];
    if (IS_ADDR) begin : g_agu
      localparam int A = u / `UNITS_PER_SIDE;
      assign agu_off[A*`OFF_BITS +: `OFF_BITS] =
        lng ? ins[`LOFF_MSB:`LOFF_LSB] : {10'h000, ins[`SOFF_MSB:`SOFF_LSB]};
      assign agu_circ[A] = ~lng & ins[`CIRC_BIT];
      assign agu_size[A*2 +: 2] = lng ? ins[`LSIZE_MSB:`LSIZE_LSB] : ins[`SIZE_MSB:`SIZE_LSB];
      assign agu_dw[A] = issue[u] & ~lng & ins[`DW_BIT] & ~st;
      assign agu_st[A] = st;
    end
  end

  // cross write bus: one write per destination side per cycle
  wire [`UNITS-1:0] wr_side;
  wire [`UNITS-1:0] xw_req;
  wire [`UNITS-1:0] wb_ok;
  for (genvar u = 0; u < `UNITS; u++) begin : g_wr
    localparam logic SIDE = (u >= `UNITS_PER_SIDE);
    assign wr_side[u] = SIDE ^ wb_cross_i[u];
    assign xw_req[u] = wb_en_i[u] & wb_cross_i[u];
  end
  wire [`UNITS-1:0] xw_grant = {first4(xw_req[7:4]), first4(xw_req[3:0])};
  assign wb_ok = wb_en_i & (~wb_cross_i | xw_grant);

  // register file writes; later units win a same-register collision
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int s = 0; s < 2; s++) begin
        for (int r = 0; r < `REG_COUNT; r++) begin
          rf_q[s][r] <= '0;
        end
      end
    end else begin
      for (int u = 0; u < `UNITS; u++) begin
        if (wb_ok[u]) begin
          rf_q[wr_side[u]][wb_addr_i[u*4 +: 4]] <= wb_data_i[u*`WORD_BITS +: `WORD_BITS];
        end
      end
      // a double-word load fills the odd partner of its even register
      for (int a = 0; a < 2; a++) begin
        if (dw_en_i[a] & wb_ok[a*`UNITS_PER_SIDE + 3]) begin
          rf_q[wr_side[a*`UNITS_PER_SIDE + 3]][{wb_addr_i[(a*`UNITS_PER_SIDE + 3)*4 + 1 +: 3], 1'b1}] <=
            dw_data_i[a*`WORD_BITS +: `WORD_BITS];
        end
      end
    end
  end


  // registered dispatch outputs

  logic group_valid_q;
  logic [`UNITS-1:0] unit_valid_q;
  logic [`FETCH_BITS-1:0] unit_instr_q;
  logic [`UNITS-1:0] unit_fp_q;
  logic [`FETCH_BITS-1:0] src1_q;
  logic [`FETCH_BITS-1:0] src2_q;
  logic [2*`OFF_BITS-1:0] agu_off_q;
  logic [1:0] agu_circ_q;
  logic [3:0] agu_size_q;
  logic [1:0] agu_dw_q;
  logic [1:0] agu_st_q;
  logic xr_conf_q;
  logic xw_conf_q;
  logic clash_q;

  // losers of either cross bus are reported, not retried, to keep one group per clock
  wire xr_conf = |(xr_req & ~xr_grant);
  wire xw_conf = |(xw_req & ~xw_grant);

  // every unit output lands in the same cycle, so the group executes together
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      group_valid_q <= 1'b0;
      unit_valid_q <= '0;
      unit_instr_q <= '0;
      unit_fp_q <= '0;
      src1_q <= '0;
      src2_q <= '0;
    end else begin
      group_valid_q <= dispatching;
      unit_valid_q <= issue;
      unit_instr_q <= route_instr;
      unit_fp_q <= fp_ok;
      src1_q <= rd1_data;
      src2_q <= rd2_data;
    end
  end

  // address unit decode and fault flags
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      agu_off_q <= '0;
      agu_circ_q <= 2'h0;
      agu_size_q <= 4'h0;
      agu_dw_q <= 2'h0;
      agu_st_q <= 2'h0;
      xr_conf_q <= 1'b0;
      xw_conf_q <= 1'b0;
      clash_q <= 1'b0;
    end else begin
      agu_off_q <= agu_off;
      agu_circ_q <= agu_circ;
      agu_size_q <= agu_size;
      agu_dw_q <= agu_dw;
      agu_st_q <= agu_st;
      xr_conf_q <= xr_conf;
      xw_conf_q <= xw_conf;
      clash_q <= route_clash;
    end
  end

  // port drive, straight from flops
  assign fetch_req_o = fetch_req_q;
  assign fetch_addr_o = fetch_addr_q;
  assign group_valid_o = group_valid_q;
  assign unit_valid_o = unit_valid_q;
  assign unit_instr_o = unit_instr_q;
  assign unit_fp_o = unit_fp_q;
  assign src1_data_o = src1_q;
  assign src2_data_o = src2_q;
  assign agu_offset_o = agu_off_q;
  assign agu_circular_o = agu_circ_q;
  assign agu_size_o = agu_size_q;
  assign agu_dw_o = agu_dw_q;
  assign agu_store_o = agu_st_q;
  assign cross_read_conflict_o = xr_conf_q;
  assign cross_write_conflict_o = xw_conf_q;
  assign unit_clash_o = clash_q;

endmodule // vliw_fetch_dispatch_unit

// *** test/prog_mem_model.sv ***
// program memory model handing out queued 256-bit fetch packets
`timescale 1ns/1ps
`include "vliw_fd_defines.svh"
module prog_mem_model (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // request and answer
  input wire logic fetch_req_i,
  input wire logic [3:0] delay_i,
  output logic fetch_valid_o,
  output logic [`FETCH_BITS-1:0] fetch_data_o
);
  // packets are padded by the bench so no group straddles a boundary
  logic [`FETCH_BITS-1:0] pkt_q [$];
  logic [3:0] wait_q;

  // answer after delay_i cycles; stale data scrambled
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fetch_valid_o <= 1'b0;
      fetch_data_o <= '0;
      wait_q <= 4'h0;
    end else if (fetch_valid_o) begin
      fetch_valid_o <= 1'b0;
      fetch_data_o <= ~fetch_data_o;
      wait_q <= 4'h0;
    end else if (fetch_req_i && pkt_q.size() > 0 && wait_q >= delay_i) begin
      fetch_valid_o <= 1'b1;
      fetch_data_o <= pkt_q.pop_front();
    end else begin
      fetch_data_o <= ~fetch_data_o;
      wait_q <= (fetch_req_i && pkt_q.size() > 0) ? wait_q + 4'h1 : 4'h0;
    end
  end
endmodule // prog_mem_model

// *** test/testbench.sv ***
// self-checking bench for the fetch and dispatch front end
`timescale 1ns/1ps
`include "vliw_fd_defines.svh"
module testbench;
  logic sys_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic fetch_req_o, fetch_valid_i, group_valid_o, cross_read_conflict_o, cross_write_conflict_o, unit_clash_o;
  logic [31:0] fetch_addr_o;
  logic [31:0] wb_addr_i = '0;
  logic [255:0] fetch_data_i, unit_instr_o, src1_data_o, src2_data_o;
  logic [255:0] wb_data_i = '0;
  logic [7:0] unit_valid_o, unit_fp_o;
  logic [7:0] wb_en_i = '0;
  logic [7:0] wb_cross_i = '0;
  logic [29:0] agu_offset_o;
  logic [1:0] agu_circular_o, agu_dw_o, agu_store_o;
  logic [1:0] dw_en_i = '0;
  logic [3:0] agu_size_o;
  logic [3:0] delay = 4'h0;
  logic [63:0] dw_data_i = '0;
  int n_fail = 0, samples_checked = 0, cyc = 0, n_clash = 0, n_rconf = 0, n_wconf = 0;
  int g_cyc[$], f_cyc[$];
  logic [7:0] g_uv[$], g_fp[$];
  logic [255:0] g_in[$], g_s1[$], g_s2[$];
  logic [39:0] g_agu[$];
  logic [31:0] f_addr[$];

  always #5 sys_clk_i = ~sys_clk_i;

  vliw_fetch_dispatch_unit vliw_fetch_dispatch_unit_inst (.sys_clk_i, .rst_n_i, .fetch_req_o, .fetch_addr_o,
    .fetch_valid_i, .fetch_data_i, .group_valid_o, .unit_valid_o, .unit_instr_o, .unit_fp_o, .src1_data_o,
    .src2_data_o, .agu_offset_o, .agu_circular_o, .agu_size_o, .agu_dw_o, .agu_store_o, .wb_en_i, .wb_addr_i,
    .wb_cross_i, .wb_data_i, .dw_en_i, .dw_data_i, .cross_read_conflict_o, .cross_write_conflict_o, .unit_clash_o);
  prog_mem_model prog_mem_model_inst (.sys_clk_i, .rst_n_i, .fetch_req_i(fetch_req_o), .delay_i(delay),
    .fetch_valid_o(fetch_valid_i), .fetch_data_o(fetch_data_i));

  // log takes and groups by cycle
  always @(posedge sys_clk_i) begin
    cyc++;
    if (fetch_req_o === 1'b1 && fetch_valid_i === 1'b1) begin
      f_cyc.push_back(cyc);
      f_addr.push_back(fetch_addr_o);
    end
    if (group_valid_o === 1'b1) begin
      g_cyc.push_back(cyc);
      g_uv.push_back(unit_valid_o);
      g_fp.push_back(unit_fp_o);
      g_in.push_back(unit_instr_o);
      g_s1.push_back(src1_data_o);
      g_s2.push_back(src2_data_o);
      g_agu.push_back({agu_offset_o, agu_circular_o, agu_size_o, agu_dw_o, agu_store_o});
    end
    n_clash += (unit_clash_o === 1'b1);
    n_rconf += (cross_read_conflict_o === 1'b1);
    n_wconf += (cross_write_conflict_o === 1'b1);
  end

  // compute word, float bit set
  function automatic logic [31:0] cw(input logic [2:0] cr, input logic z, input logic [3:0] s1, input logic x,
                                     input logic [2:0] u, input logic ch);
    return {cr, z, 4'h0, 1'b0, s1, x, 4'h0, 1'b1, 9'h000, u, ch};
  endfunction

  // short address word, offset 0x15
  function automatic logic [31:0] sw(input logic [3:0] base, input logic [2:0] u, input logic ch);
    return {3'h0, 1'b0, 4'h0, 1'b0, 1'b0, base, 1'b1, 1'b1, 1'b0, 2'h2, 5'h15, 4'h0, u, ch};
  endfunction

  task automatic end_sim();
    $display("checks %0d failures %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic check(input string what, input logic [255:0] seen, input logic [255:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // clear on an edge so the monitor never sees half a log
  task automatic clr();
    @(posedge sys_clk_i);
    g_cyc.delete(); g_uv.delete(); g_fp.delete(); g_in.delete(); g_s1.delete(); g_s2.delete(); g_agu.delete();
    f_cyc.delete(); f_addr.delete();
    n_clash = 0; n_rconf = 0; n_wconf = 0;
  endtask

  task automatic put(input logic [255:0] p);
    prog_mem_model_inst.pkt_q.push_back(p);
  endtask

  task automatic wait_groups(input int n);
    for (int t = 0; t < 300 && g_cyc.size() < n; t++) @(posedge sys_clk_i);
    if (g_cyc.size() < n) begin
      n_fail++;
      $display("ERROR group count expected %0d seen %0d", n, g_cyc.size());
      end_sim();
    end
    repeat (4) @(posedge sys_clk_i);
    check("group count", g_cyc.size(), n);
  endtask

  task automatic split_scenario();
    logic [255:0] p;
    logic [7:0] exp_uv [11];
    clr();
    for (int k = 0; k < 3; k++) begin
      for (int s = 0; s < 8; s++) p[32*s +: 32] = cw(3'h0, 1'b0, 4'h0, 1'b0, 3'(s), k > 0 && s != 7 && (k == 1 || s != 2));
      put(p);
    end
    wait_groups(11);
    exp_uv = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h40, 8'h80, 8'hFF, 8'h07, 8'hF8};
    for (int s = 0; s < 11; s++) check("group units", g_uv[s], exp_uv[s]);
    for (int s = 0; s < 10; s++) if (s != 7 && s != 8) check("group gap", g_cyc[s+1] - g_cyc[s], 1);
    check("first address", f_addr[0], `RESET_PC);
    for (int s = 0; s < 2; s++) check("address step", f_addr[s+1] - f_addr[s], `FETCH_STEP);
    check("fetch after packet", (f_cyc[1] > g_cyc[7]) && (f_cyc[2] > g_cyc[8]), 1);
  endtask

  task automatic route_scenario();
    logic [255:0] p;
    logic [2:0] u [4] = '{3'h5, 3'h0, 3'h3, 3'h2};
    clr();
    for (int s = 0; s < 4; s++) p[32*s +: 32] = cw(3'h0, 1'b0, 4'h0, 1'b0, u[s], s != 3);
    p[159:128] = cw(3'h0, 1'b0, 4'h0, 1'b0, 3'h1, 1'b1);
    p[191:160] = cw(3'h0, 1'b0, 4'h0, 1'b0, 3'h1, 1'b0);
    p[223:192] = cw(3'h7, 1'b0, 4'h0, 1'b0, 3'h4, 1'b0);
    p[255:224] = cw(3'h6, 1'b0, 4'h0, 1'b0, 3'h6, 1'b0);
    put(p);
    wait_groups(4);
    check("routed units", g_uv[0], 8'h2D);
    check("float units", g_fp[0], 8'h25);
    for (int s = 0; s < 4; s++) check("routed word", g_in[0][32*u[s] +: 32], p[32*s +: 32]);
    check("clash flag", n_clash, 1);
    check("idle units", {g_uv[2], g_uv[3]}, 16'h0000);
  endtask

  // register files still all zero here
  task automatic cond_scenario();
    logic [255:0] p;
    clr();
    for (int k = 0; k < 2; k++) begin
      for (int s = 0; s < 8; s++) p[32*s +: 32] = cw(3'(s), k[0], 4'h0, 1'b0, 3'h0, 1'b0);
      put(p);
    end
    wait_groups(16);
    for (int k = 0; k < 16; k++) check("conditional issue", g_uv[k][0], k % 8 == 0 || (k % 8 < 6 && k >= 8));
  endtask

  task automatic regfile_scenario();
    logic [255:0] p;
    clr();
    wb_en_i <= 8'h3F;
    wb_cross_i <= 8'h30;
    wb_addr_i <= 32'h00984321;
    wb_data_i <= {64'h0, 32'hB5B50005, 32'hB4B40004, 128'hA3A30003A2A20002A1A10001A0A00000};
    dw_en_i <= 2'b01;
    dw_data_i <= {32'h00000000, 32'hD0D00001};
    @(posedge sys_clk_i);
    wb_en_i <= 8'h00;
    dw_en_i <= 2'b00;
    repeat (3) @(posedge sys_clk_i);
    check("cross write flag", n_wconf, 1);
    for (int s = 0; s < 3; s++) p[32*s +: 32] = cw(3'h0, 1'b0, 4'(s + 1), 1'b0, 3'(s), 1'b1);
    p[127:96] = sw(4'h4, 3'h3, 1'b0);
    p[159:128] = cw(3'h0, 1'b0, 4'h8, 1'b1, 3'h4, 1'b1);
    p[191:160] = cw(3'h0, 1'b0, 4'h5, 1'b1, 3'h5, 1'b0);
    p[223:192] = cw(3'h0, 1'b0, 4'h9, 1'b1, 3'h4, 1'b1);
    p[255:224] = cw(3'h0, 1'b0, 4'h5, 1'b0, 3'h0, 1'b0);
    put(p);
    wait_groups(3);
    check("same side reads", g_s1[0][127:0], 128'hA3A30003A2A20002A1A10001A0A00000);
    check("cross reads", g_s1[1][191:128], 64'h00000000B4B40004);
    check("cross read flag", n_rconf, 1);
    check("dropped cross write", g_s1[2][159:128], 32'h00000000);
    check("double word", g_s1[2][31:0], 32'hD0D00001);
  endtask

  // slow memory; short and long address forms
  task automatic agu_scenario();
    logic [255:0] p;
    clr();
    delay <= 4'h3;
    p = {8{cw(3'h7, 1'b0, 4'h0, 1'b0, 3'h0, 1'b0)}};
    p[31:0] = sw(4'h1, 3'h3, 1'b1);
    p[63:32] = {3'h0, 1'b0, 4'h1, 1'b1, 1'b1, 15'h4ABC, 1'b1, 2'h1, 3'h7, 1'b0};
    put(p);
    wait_groups(7);
    check("address units", g_uv[0], 8'h88);
    check("address decode", g_agu[0], {15'h4ABC, 15'h0015, 2'b01, 4'h6, 2'b01, 2'b10});
    check("base operand", g_s1[0][127:96], 32'hA0A00000);
    check("cross store data", g_s2[0][255:224], 32'hA0A00000);
    check("fetch latency", g_cyc[0] - f_cyc[0], 2);
  endtask

  // main sequence
  initial begin
    repeat (6) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    split_scenario();
    route_scenario();
    cond_scenario();
    regfile_scenario();
    agu_scenario();
    end_sim();
  end
endmodule // testbench

bind vliw_fetch_dispatch_unit vliw_fd_checker vliw_fd_checker_inst (.sys_clk_i, .rst_n_i, .fetch_req_o,
  .fetch_addr_o, .fetch_valid_i, .group_valid_o, .unit_valid_o, .unit_fp_o, .agu_dw_o, .wb_en_i, .wb_cross_i,
  .cross_write_conflict_o);

// *** test/vliw_fd_checker.sv ***
// concurrent checks on the ports of the fetch and dispatch front end
`timescale 1ns/1ps
`include "vliw_fd_defines.svh"
module vliw_fd_checker (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // program memory side
  input wire logic fetch_req_o,
  input wire logic [31:0] fetch_addr_o,
  input wire logic fetch_valid_i,
  // dispatch side
  input wire logic group_valid_o,
  input wire logic [`UNITS-1:0] unit_valid_o,
  input wire logic [`UNITS-1:0] unit_fp_o,
  input wire logic [1:0] agu_dw_o,
  // write back side
  input wire logic [`UNITS-1:0] wb_en_i,
  input wire logic [`UNITS-1:0] wb_cross_i,
  input wire logic cross_write_conflict_o
);
  logic take;
  logic seen_q;
  logic seen_d;
  logic [31:0] taken_q;
  logic [31:0] taken_d;
  logic [3:0] grp_cnt_q;
  logic [3:0] grp_cnt_d;

  // last take and groups since
  assign take = fetch_req_o && fetch_valid_i;
  assign seen_d = seen_q || take;
  assign taken_d = take ? fetch_addr_o : taken_q;
  assign grp_cnt_d = take ? 4'h0 : (group_valid_o ? grp_cnt_q + 4'h1 : grp_cnt_q);

  // helper state
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      seen_q <= 1'b0;
      taken_q <= 32'h00000000;
      grp_cnt_q <= 4'h0;
    end else begin
      seen_q <= seen_d;
      taken_q <= taken_d;
      grp_cnt_q <= grp_cnt_d;
    end
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  property p_hold_request; fetch_req_o && !fetch_valid_i |=> fetch_req_o && $stable(fetch_addr_o); endproperty
  a_hold_request: assert property (p_hold_request) else $error("request dropped before taken");
  property p_drop_request; take |=> !fetch_req_o; endproperty
  a_drop_request: assert property (p_drop_request) else $error("request stays after take");
  property p_step_address; $rose(fetch_req_o) && seen_q |-> fetch_addr_o == taken_q + `FETCH_STEP; endproperty
  a_step_address: assert property (p_step_address) else $error("fetch address step wrong");
  property p_first_group; take |-> ##2 group_valid_o; endproperty
  a_first_group: assert property (p_first_group) else $error("first group late");
  property p_no_overlap; fetch_req_o |=> !group_valid_o; endproperty
  a_no_overlap: assert property (p_no_overlap) else $error("group after next request");
  property p_steady_issue; group_valid_o && !fetch_req_o |=> group_valid_o; endproperty
  a_steady_issue: assert property (p_steady_issue) else $error("gap between groups");
  property p_group_count; group_valid_o |-> grp_cnt_q < 4'h8; endproperty
  a_group_count: assert property (p_group_count) else $error("more than eight groups");
  property p_fp_units; unit_fp_o != 8'h00 |-> !unit_fp_o[3] && !unit_fp_o[7] && (unit_fp_o & ~unit_valid_o) == 8'h00;
  endproperty
  a_fp_units: assert property (p_fp_units) else $error("float flag on wrong unit");
  property p_idle_units; unit_valid_o != 8'h00 |-> group_valid_o; endproperty
  a_idle_units: assert property (p_idle_units) else $error("unit busy outside a group");
  property p_double_load; agu_dw_o[0] |-> unit_valid_o[3]; endproperty
  a_double_load: assert property (p_double_load) else $error("double load without address unit");
  property p_cross_write; $countones(wb_en_i[7:4] & wb_cross_i[7:4]) > 1 |=> cross_write_conflict_o; endproperty
  a_cross_write: assert property (p_cross_write) else $error("cross write conflict missed");
endmodule // vliw_fd_checker
